// ==== shared/dmts_defs.svh ====
`ifndef DMTS_DEFS_SVH
`define DMTS_DEFS_SVH
// Register word addresses
`define DMTS_ADDR_STATUS 8'h00
`define DMTS_ADDR_IRQ_STAT 8'h04
`define DMTS_ADDR_IRQ_MASK 8'h08
`define DMTS_ADDR_CTRL 8'h0C
// Status word field positions
`define DMTS_BIT_FIRST_ERR 7
`define DMTS_BIT_SECOND_ERR 6
`define DMTS_BIT_EVENT 5
`define DMTS_BIT_WINDOW 0
// Interrupt status/mask bit positions
`define DMTS_IRQ_FIRST 0
`define DMTS_IRQ_SECOND 1
`define DMTS_IRQ_EVENT 2
`define DMTS_IRQ_WINDOW 3
`define DMTS_IRQ_W 4
// Reset values
`define DMTS_FLAGS_RST 4'h0
`define DMTS_MASK_RST 4'h0
// Default key values
`define DMTS_KEY1_DEF 8'h40
`define DMTS_KEY2_DEF 8'h08
`endif

// ==== shared/dmts_pkg.sv ====
package dmts_pkg;
  // Progress through the two key steps
  typedef enum logic [1:0] {
    DMTS_IDLE = 2'b00,
    DMTS_GOT1 = 2'b01
  } dmts_key_st_t;
endpackage

// ==== hw/dmts_flag_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
// One sticky flag: set wins over clear
module dmts_flag_cell (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Control
  input wire logic set_in,
  input wire logic clr_in,
  // State
  output logic flag_out
);
  // Flag register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flag_out <= 1'b0;
    end else if (clk_en) begin
      if (set_in) begin
        // Set has priority
        flag_out <= 1'b1;
      end else if (clr_in) begin
        flag_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/dmts_status.sv ====
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dmts_defs.svh"
module dmts_status
  import dmts_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int KEY_W = 8
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Key step writes from the unit
  input wire logic key1_wr,
  input wire logic [KEY_W-1:0] key1_data,
  input wire logic key2_wr,
  input wire logic [KEY_W-1:0] key2_data,
  // Timer state from the counter
  input wire logic count_expired,
  input wire logic count_inc,
  input wire logic window_open_in,
  input wire logic flags_clear,
  // Interrupt
  output logic irq
);
  // Flag state seen in the status word
  // Set by a wrong first key step
  logic first_key_error_flag;
  // Set by a wrong second key step
  logic second_key_error_flag;
  // Set by expiry or any wrong key step
  logic timer_event_flag;
  // Clear window, one cycle behind the counter
  logic clear_window_open_flag;
  // Key sequence state
  dmts_key_st_t key_st_reg;
  dmts_key_st_t key_st_next;
  // Software key values
  logic [KEY_W-1:0] key1_val_reg; // Expected first step
  logic [KEY_W-1:0] key2_val_reg; // Expected second step
  // Interrupt status and mask
  logic [`DMTS_IRQ_W-1:0] irq_stat_reg; // Sticky, write one to clear
  logic [`DMTS_IRQ_W-1:0] irq_mask_reg; // One enables a status bit
  // Wrong first key step this cycle
  logic key1_wrong;
  // Wrong second key step this cycle
  logic key2_wrong;
  // Any cause of a timer event this cycle
  logic event_hit;
  // Clear window seen opening this cycle
  logic window_rise;
  // Interrupt events of this cycle
  logic [`DMTS_IRQ_W-1:0] ev;

  // Address match helper
  // True when the port address selects the given register
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] r);
    hit = (a == ADDR_W'(r));
  endfunction

  // first key compare against the stored value
  assign key1_wrong = key1_wr && (key1_data != key1_val_reg);
  // second key compare; out of order counts as wrong
  // since the first step was never accepted
  assign key2_wrong = key2_wr && ((key2_data != key2_val_reg) || (key_st_reg != DMTS_GOT1));
  // expiry or a wrong step of either key
  assign event_hit = count_expired || key1_wrong || key2_wrong;

  // Key sequence next state
  always_comb begin
    key_st_next = key_st_reg;
    unique case (key_st_reg)
      DMTS_IDLE: begin
        // Good first step opens the sequence
        if (key1_wr && !key1_wrong) begin
          key_st_next = DMTS_GOT1;
        end
      end
      DMTS_GOT1: begin
        // Any second step or a wrong first step ends it
        if (key2_wr || key1_wrong) begin
          key_st_next = DMTS_IDLE;
        end
      end
      // Illegal codes fall back to idle
      default: key_st_next = DMTS_IDLE;
    endcase
  end

  // Key sequence register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      // Sequence starts idle
      key_st_reg <= DMTS_IDLE;
    end else if (clk_en) begin
      // Counter increment or hardware clear restarts the sequence
      key_st_reg <= (count_inc || flags_clear) ? DMTS_IDLE : key_st_next;
    end
  end

  // Key value control register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      key1_val_reg <= KEY_W'(`DMTS_KEY1_DEF);
      key2_val_reg <= KEY_W'(`DMTS_KEY2_DEF);
    end else if (clk_en && reg_wr && hit(reg_addr, `DMTS_ADDR_CTRL)) begin
      // Both key values come from one control word
      key1_val_reg <= reg_wdata[KEY_W-1:0];
      key2_val_reg <= reg_wdata[KEY_W+7:8];
    end
  end

  // Hardware clear drops all three sticky flags; a new event wins
  // first key error flag
  dmts_flag_cell u_first (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .set_in(key1_wrong),
    .clr_in(flags_clear),
    .flag_out(first_key_error_flag)
  );
  dmts_flag_cell u_second (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .set_in(key2_wrong),
    .clr_in(flags_clear),
    .flag_out(second_key_error_flag)
  );
  dmts_flag_cell u_event (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .set_in(event_hit),
    .clr_in(flags_clear),
    .flag_out(timer_event_flag)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clear_window_open_flag <= 1'b0;
    end else if (clk_en) begin
      // Flag follows the counter's window level
      clear_window_open_flag <= window_open_in;
    end
  end

  // Open edge of the clear window, for the interrupt
  assign window_rise = window_open_in && !clear_window_open_flag;
  // Interrupt event vector
  always_comb begin
    // One bit per interrupt source
    ev = '0;
    ev[`DMTS_IRQ_FIRST] = key1_wrong;
    ev[`DMTS_IRQ_SECOND] = key2_wrong;
    ev[`DMTS_IRQ_EVENT] = event_hit;
    ev[`DMTS_IRQ_WINDOW] = window_rise;
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_stat_reg <= `DMTS_FLAGS_RST;
    end else if (clk_en) begin
      if (reg_wr && hit(reg_addr, `DMTS_ADDR_IRQ_STAT)) begin
        // Write one clears, a new event still sets
        irq_stat_reg <= (irq_stat_reg & ~reg_wdata[`DMTS_IRQ_W-1:0]) | ev;
      end else begin
        // No write, events accumulate
        irq_stat_reg <= irq_stat_reg | ev;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_mask_reg <= `DMTS_MASK_RST;
    end else if (clk_en && reg_wr && hit(reg_addr, `DMTS_ADDR_IRQ_MASK)) begin
      // Mask bits follow the written word
      irq_mask_reg <= reg_wdata[`DMTS_IRQ_W-1:0];
    end
  end

  // Interrupt output register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      // One cycle behind the status and mask
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read data, unused bits zero; status word writes ignored
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      // Nothing stands on the read port in reset
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      // Read data stand one cycle, else zero
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        if (hit(reg_addr, `DMTS_ADDR_STATUS)) begin
          // Status word, unused bits stay zero
          reg_rdata[`DMTS_BIT_FIRST_ERR] <= first_key_error_flag;
          reg_rdata[`DMTS_BIT_SECOND_ERR] <= second_key_error_flag;
          reg_rdata[`DMTS_BIT_EVENT] <= timer_event_flag;
          reg_rdata[`DMTS_BIT_WINDOW] <= clear_window_open_flag;
        end else if (hit(reg_addr, `DMTS_ADDR_IRQ_STAT)) begin
          // Interrupt status
          reg_rdata[`DMTS_IRQ_W-1:0] <= irq_stat_reg;
        end else if (hit(reg_addr, `DMTS_ADDR_IRQ_MASK)) begin
          // Interrupt mask
          reg_rdata[`DMTS_IRQ_W-1:0] <= irq_mask_reg;
        end else if (hit(reg_addr, `DMTS_ADDR_CTRL)) begin
          // Key values, first step in the low byte
          reg_rdata[KEY_W-1:0] <= key1_val_reg;
          reg_rdata[KEY_W+7:8] <= key2_val_reg;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/dmts_status_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmts_defs.svh"
module dmts_status_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Watched ports
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic key1_wr,
  input wire logic [7:0] key1_data,
  input wire logic key2_wr,
  input wire logic [7:0] key2_data,
  input wire logic count_expired,
  input wire logic window_open_in,
  input wire logic flags_clear,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Status read with no hardware clear beside it
  wire logic rd_st = reg_rd && clk_en && reg_addr == 8'h00 && !flags_clear;
  chk_unused_zero: assert property (rd_st |=> reg_rdata[31:8] == 24'h0 && reg_rdata[4:1] == 4'h0)
    else $error("unused status bits not zero");
  chk_window_flag: assert property (rd_st && $past(clk_en) |=>
    reg_rdata[0] == $past(window_open_in, 2))
    else $error("window flag wrong");
  chk_first_bad: assert property (key1_wr && clk_en && key1_data != `DMTS_KEY1_DEF ##1
    (!flags_clear throughout ##[0:2] rd_st) |=> reg_rdata[7] && reg_rdata[5])
    else $error("first key error not flagged");
  chk_second_bad: assert property (key2_wr && clk_en && key2_data != `DMTS_KEY2_DEF ##1
    (!flags_clear throughout ##[0:1] rd_st) |=> reg_rdata[6])
    else $error("second key error not flagged");
  chk_expiry_event: assert property (count_expired && clk_en ##1
    (!flags_clear throughout ##[0:2] rd_st) |=> reg_rdata[5])
    else $error("expiry event not flagged");
  chk_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> reg_rdata == 32'h0 && !irq)
    else $error("outputs not zero in reset");
endmodule
bind dmts_status dmts_status_monitor u_mon (.clk_sys(clk_sys), .reset_n(reset_n),
  .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key1_wr(key1_wr),
  .key1_data(key1_data), .key2_wr(key2_wr), .key2_data(key2_data), .irq(irq),
  .count_expired(count_expired), .window_open_in(window_open_in), .flags_clear(flags_clear));
`default_nettype wire

// ==== tb/dmts_status_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmts_status_tb;
  logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, key1_wr = 0, key2_wr = 0;
  logic clk_en = 1, count_inc = 0;
  logic count_expired = 0, window_open_in = 0, flags_clear = 0, irq, w, f1, f2;
  logic [7:0] reg_addr = 0, key1_data = 0, key2_data = 0, v1, v2;
  logic [31:0] reg_wdata = 0, reg_rdata, d;
  int err_total = 0, checked = 0;
  // Clock at 40 MHz
  always #12.5 clk_sys = ~clk_sys;
  dmts_status DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .key1_wr(key1_wr), .key1_data(key1_data), .key2_wr(key2_wr), .key2_data(key2_data),
    .count_expired(count_expired), .count_inc(count_inc), .window_open_in(window_open_in),
    .flags_clear(flags_clear), .irq(irq));
  // Compare and count
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Register write and read cycles
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk_sys) reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys) reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  // Both key steps back to back
  task keys(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_sys) {key1_wr, key1_data} <= {1'b1, a};
    @(posedge clk_sys) {key1_wr, key2_wr, key2_data} <= {2'b01, b};
    @(posedge clk_sys) key2_wr <= 0;
  endtask
  task clr;
    @(posedge clk_sys) flags_clear <= 1;
    @(posedge clk_sys) flags_clear <= 0;
  endtask
  task wait2;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Expected status word
  function logic [31:0] st(input logic a, input logic b, input logic c, input logic e);
    return {24'h0, a, b, c, 4'h0, e};
  endfunction
  task finish_test;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h5e36a129));
    repeat (16) @(posedge clk_sys);
    reset_n <= 1;
    rd(8'h00);
    chk(d, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00);
    chk(d, 32'h0);
    rd(8'h10);
    chk(d, 32'h0);
    $display("reset and write test done");
    // Bad first key, interrupt masked then enabled then cleared
    keys(8'h41, 8'h08);
    wait2;
    chk(irq, 0);
    rd(8'h04);
    chk(d, 32'h7);
    wr(8'h08, 32'hF);
    wait2;
    chk(irq, 1);
    wr(8'h04, 32'h7);
    wait2;
    chk(irq, 0);
    rd(8'h00);
    chk(d, st(1, 1, 1, 0));
    $display("interrupt test done");
    // Random key values with good keys mixed in
    repeat (24) begin
      v1 = $urandom_range(1) ? 8'h40 : 8'($urandom);
      v2 = $urandom_range(1) ? 8'h08 : 8'($urandom);
      w = 1'($urandom);
      clr;
      window_open_in <= w;
      keys(v1, v2);
      rd(8'h00);
      f1 = v1 != 8'h40;
      f2 = f1 || v2 != 8'h08;
      chk(d, st(f1, f2, f2, w));
    end
    $display("random key test done");
    // Counter expiry alone
    clr;
    @(posedge clk_sys) count_expired <= 1;
    @(posedge clk_sys) count_expired <= 0;
    rd(8'h00);
    chk(d, st(0, 0, 1, w));
    $display("expiry test done");
    // Hand corners: good pair, restart by counter increment, frozen enable
    clr;
    keys(8'h40, 8'h08);
    rd(8'h00);
    chk(d, st(0, 0, 0, w));
    clr;
    @(posedge clk_sys) {key1_wr, key1_data} <= {1'b1, 8'h40};
    @(posedge clk_sys) {key1_wr, count_inc} <= 2'b01;
    @(posedge clk_sys) {count_inc, key2_wr, key2_data} <= {2'b01, 8'h08};
    @(posedge clk_sys) key2_wr <= 0;
    rd(8'h00);
    chk(d, st(0, 1, 1, w));
    clr;
    @(posedge clk_sys) {clk_en, key1_wr, key1_data, count_expired} <= {2'b01, 8'h13, 1'b1};
    @(posedge clk_sys) {clk_en, key1_wr, count_expired} <= 3'b100;
    rd(8'h00);
    chk(d, st(0, 0, 0, w));
    $display("corner test done");
    // Key value word, then a reset in mid-run restores every default
    v1 = 8'($urandom);
    v2 = 8'($urandom);
    wr(8'h0C, {16'h0, v2, v1});
    rd(8'h0C);
    chk(d, {16'h0, v2, v1});
    @(posedge clk_sys) {reset_n, window_open_in} <= 2'b00;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1;
    rd(8'h00);
    chk(d, 32'h0);
    chk(irq, 0);
    rd(8'h0C);
    chk(d, {16'h0, 8'h08, 8'h40});
    rd(8'h08);
    chk(d, 32'h0);
    // Window opening raises its own interrupt source
    @(posedge clk_sys) window_open_in <= 1;
    wait2;
    rd(8'h04);
    chk(d, 32'h8);
    rd(8'h00);
    chk(d, st(0, 0, 0, 1));
    $display("reset and window test done");
    finish_test;
  end
endmodule
`default_nettype wire
